/* design/bus_interface_reset_manager.sv */
// reset and initialisation manager for the instrument-bus side, APB slave
//
// Functional notes
// - the hardware reset pin enters native mode and does both the transfer and bus-side resets.
// - the reset pin is the PCI reset in PCI-host mode, the generic pin otherwise; PCI reset also resets the PCI interface.
// - transfer command 0x22 resets the transfer manager only, not talker, listener or poll logic.
// - that reset clears transfer config, handshake select and third mask, sets done and stopped, flushes the FIFO.
// - that reset sets the transfer byte counters to 16-bit counting.
// - that reset places the device in native register mode.
// - transfer command 0x40 acts exactly like the hardware reset pin.
// - auxiliary command 0x02 asserts the local power-on message, disconnecting from the bus.
// - after the bus-side reset the power-on message stays until software clears it.
// - the bus-side reset clears serial poll, auxiliary, bus control, misc, interrupt enable, end-of-string and settle delay.
// - the bus-side reset clears the individual status flag and sets poll mode one in the poll config.
// - auxiliary command 0x00 asserts the power-on message for one cycle then releases it.
// - once the pulse releases the message the device is reconnected to the bus.
// - hardware and transfer resets set the synchronized flag; only a later go clears it.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module bus_interface_reset_manager (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic      [31:0]                prdata,
	output logic                            pslverr,
	// reset pins and host mode strap
	input  wire logic                       pci_host_mode,
	input  wire logic                       pci_rst_n,
	input  wire logic                       gen_rst_n,
	// reset actions towards the rest of the device
	output logic                            pci_if_reset,
	output logic                            xfer_mgr_reset,
	output logic                            bus_side_reset,
	output logic                            fifo_flush,
	// state of this manager
	output reset_mgr_pkg::reset_state_t     state,
	output reset_mgr_pkg::cfg_bank_t        cfg_regs
);
	logic [7:0]  idx;
	logic        aligned;
	logic        in_cfg;
	logic        mapped;
	logic        wr_hit;
	logic        xfer_cmd_wr;
	logic        aux_cmd_wr;
	logic        ctl_wr;
	logic [7:0]  wbyte;
	logic        pin_reset;
	logic        full_reset;
	logic        xfer_reset;
	logic        chip_reset;
	logic        go_cmd;
	logic        pon_pulse_cmd;
	logic [7:0]  cfg_off;
	logic [7:0]  status_byte;
	logic [7:0]  control_byte;
	logic [31:0] read_d;
	logic        pon_msg;

	// one flop per flag; a packed struct cannot take several always_ff drivers
	logic native_q;
	logic count16_q;
	logic ist_q;
	logic sync_q;
	logic done_q;
	logic stopped_q;

	reset_mgr_pkg::reset_state_t st_q;

	// address decode
	assign idx     = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign cfg_off = idx - reset_mgr_pkg::IDX_CFG_BASE;
	assign in_cfg  = (idx >= reset_mgr_pkg::IDX_CFG_BASE)
		&& (cfg_off < 8'(reset_mgr_pkg::CFG_COUNT));
	assign mapped  = aligned && (in_cfg
		|| idx == reset_mgr_pkg::IDX_STATUS
		|| idx == reset_mgr_pkg::IDX_CONTROL
		|| idx == reset_mgr_pkg::IDX_AUX_CMD
		|| idx == reset_mgr_pkg::IDX_XFER_CMD);

	// a write lands only at the edge that sees pready high in the access phase
	assign wr_hit      = psel && penable && pwrite && pready && mapped;
	assign wbyte       = pwdata[7:0];
	assign xfer_cmd_wr = wr_hit && idx == reset_mgr_pkg::IDX_XFER_CMD;
	assign aux_cmd_wr  = wr_hit && idx == reset_mgr_pkg::IDX_AUX_CMD;
	assign ctl_wr      = wr_hit && idx == reset_mgr_pkg::IDX_CONTROL;

	// only the listed codes do anything; every other code falls through
	assign go_cmd        = xfer_cmd_wr && wbyte == reset_mgr_pkg::CMD_GO;
	assign pon_pulse_cmd = aux_cmd_wr && wbyte == reset_mgr_pkg::AUX_PON_PULSE;

	// pins are sampled as synchronous inputs
	assign pin_reset  = pci_host_mode ? !pci_rst_n : !gen_rst_n;
	assign full_reset = pin_reset
		|| (xfer_cmd_wr && wbyte == reset_mgr_pkg::CMD_FULL_RESET);
	assign xfer_reset = full_reset
		|| (xfer_cmd_wr && wbyte == reset_mgr_pkg::CMD_XFER_RESET);
	assign chip_reset = full_reset
		|| (aux_cmd_wr && wbyte == reset_mgr_pkg::AUX_BUS_RESET);

	// apb answers with one wait-free access phase
	always_ff @(posedge clock) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : read_d;
		end
	end

	// register bank
	genvar g;
	generate
		for (g = 0; g < reset_mgr_pkg::CFG_COUNT; g++) begin : g_cfg
			localparam logic [7:0] CLR = (g == reset_mgr_pkg::CFG_PARALLEL_POLL)
				? reset_mgr_pkg::PPC_RESET_VAL : reset_mgr_pkg::CFG_RESET_VAL;
			localparam bit IN_XFER = reset_mgr_pkg::XFER_GROUP[g];
			clearable_reg #(
				.CLR_VAL (CLR)
			) u_reg (
				.clock   (clock),
				.rst     (rst),
				.wr_en   (wr_hit && in_cfg && cfg_off == 8'(g)),
				.wr_data (wbyte),
				// transfer reset touches only its own group; talker and poll state survive
				.clr     (IN_XFER ? xfer_reset : chip_reset),
				.q       (cfg_regs[g])
			);
		end
	endgenerate

	pon_control u_pon (
		.clock (clock),
		.rst   (rst),
		.hold  (chip_reset),
		.pulse (pon_pulse_cmd),
		.pon_q (pon_msg)
	);

	// mode and counter width: reset forces them, software may change them afterwards
	always_ff @(posedge clock) begin
		if (rst || xfer_reset) begin
			native_q <= 1'b1;
		end else if (ctl_wr) begin
			native_q <= !wbyte[reset_mgr_pkg::CTL_LEGACY_MODE];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || xfer_reset) begin
			count16_q <= 1'b1;
		end else if (ctl_wr) begin
			count16_q <= wbyte[reset_mgr_pkg::CTL_COUNT_16BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || chip_reset) begin
			ist_q <= 1'b0;
		end else if (ctl_wr) begin
			ist_q <= wbyte[reset_mgr_pkg::CTL_IST];
		end
	end

	// flags set by reset beat a go landing in the same cycle
	always_ff @(posedge clock) begin
		if (rst || xfer_reset) begin
			sync_q <= 1'b1;
		end else if (go_cmd) begin
			sync_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || xfer_reset) begin
			done_q <= 1'b1;
		end else if (go_cmd) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || xfer_reset) begin
			stopped_q <= 1'b1;
		end else if (go_cmd) begin
			stopped_q <= 1'b0;
		end
	end

	always_comb begin
		st_q                   = '0;
		st_q.native_mode       = native_q;
		st_q.count_16bit       = count16_q;
		st_q.individual_status = ist_q;
		st_q.bus_synchronized  = sync_q;
		st_q.transfer_done     = done_q;
		st_q.transfer_stopped  = stopped_q;
		st_q.pon               = pon_msg;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= st_q;
		end
	end

	// action pulses, one cycle per command and as long as the reset pin is low, registered so that outputs come from flops
	always_ff @(posedge clock) begin
		if (rst) begin
			xfer_mgr_reset <= 1'b0;
			bus_side_reset <= 1'b0;
			fifo_flush     <= 1'b0;
			pci_if_reset   <= 1'b0;
		end else begin
			xfer_mgr_reset <= xfer_reset;
			bus_side_reset <= chip_reset;
			fifo_flush     <= xfer_reset;
			pci_if_reset   <= full_reset && pci_host_mode;
		end
	end

	// read mux
	always_comb begin
		status_byte = 8'h00;
		status_byte[reset_mgr_pkg::ST_SYNC]        = st_q.bus_synchronized;
		status_byte[reset_mgr_pkg::ST_STOPPED]     = st_q.transfer_stopped;
		status_byte[reset_mgr_pkg::ST_DONE]        = st_q.transfer_done;
		status_byte[reset_mgr_pkg::ST_PON]         = st_q.pon;
		status_byte[reset_mgr_pkg::ST_NATIVE]      = st_q.native_mode;
		status_byte[reset_mgr_pkg::ST_COUNT_16BIT] = st_q.count_16bit;
		status_byte[reset_mgr_pkg::ST_IST]         = st_q.individual_status;
		status_byte[reset_mgr_pkg::ST_PCI_MODE]    = pci_host_mode;
		control_byte = 8'h00;
		control_byte[reset_mgr_pkg::CTL_LEGACY_MODE] = !st_q.native_mode;
		control_byte[reset_mgr_pkg::CTL_COUNT_16BIT] = st_q.count_16bit;
		control_byte[reset_mgr_pkg::CTL_IST]         = st_q.individual_status;
		read_d = 32'h0000_0000;
		if (in_cfg) begin
			read_d[7:0] = cfg_regs[cfg_off[3:0]];
		end else if (idx == reset_mgr_pkg::IDX_STATUS) begin
			read_d[7:0] = status_byte;
		end else if (idx == reset_mgr_pkg::IDX_CONTROL) begin
			read_d[7:0] = control_byte;
		end
	end

endmodule : bus_interface_reset_manager

/* design/clearable_reg.sv */
// one software register with a hardware clear to a fixed value
`timescale 1ns/1ps
module clearable_reg #(
	parameter logic [7:0] CLR_VAL = 8'h00
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// control
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic       clr,
	// state
	output logic      [7:0] q
);
	// clear wins: a reset command beats a write landing in the same cycle
	always_ff @(posedge clock) begin
		if (rst || clr) begin
			q <= CLR_VAL;
		end else if (wr_en) begin
			q <= wr_data;
		end
	end
endmodule : clearable_reg

/* design/pon_control.sv */
// local power-on message: held by the bus-side reset, pulsed by its own command
`timescale 1ns/1ps
module pon_control (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// commands
	input  wire logic hold,
	input  wire logic pulse,
	// message
	output logic      pon_q
);
	reset_mgr_pkg::pon_state_t state_q;
	reset_mgr_pkg::pon_state_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			reset_mgr_pkg::PON_HELD:  state_d = pulse ? reset_mgr_pkg::PON_PULSE : state_q;
			reset_mgr_pkg::PON_PULSE: state_d = reset_mgr_pkg::PON_OFF;
			reset_mgr_pkg::PON_OFF:   state_d = pulse ? reset_mgr_pkg::PON_PULSE : state_q;
			default:                  state_d = reset_mgr_pkg::PON_HELD;
		endcase
		// hold outranks a pulse in the same cycle
		if (hold) begin
			state_d = reset_mgr_pkg::PON_HELD;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= reset_mgr_pkg::PON_HELD;
		end else begin
			state_q <= state_d;
		end
	end

	// pulse is exactly one cycle high, then reconnects
	always_ff @(posedge clock) begin
		if (rst) begin
			pon_q <= 1'b1;
		end else begin
			pon_q <= (state_d != reset_mgr_pkg::PON_OFF);
		end
	end
endmodule : pon_control

/* pkg/reset_mgr_pkg.sv */
// constants and types shared by the bus-interface reset manager
package reset_mgr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS   = 8'h00;
	localparam logic [7:0] IDX_CONTROL  = 8'h01;
	localparam logic [7:0] IDX_AUX_CMD  = 8'h0a;
	localparam logic [7:0] IDX_XFER_CMD = 8'h10;
	localparam logic [7:0] IDX_CFG_BASE = 8'h11;
	localparam int         CFG_COUNT    = 11;

	// order of the configuration bank, from IDX_CFG_BASE upward
	localparam int CFG_TRANSFER_CONFIG  = 0;
	localparam int CFG_HANDSHAKE_SELECT = 1;
	localparam int CFG_THIRD_INT_MASK   = 2;
	localparam int CFG_SERIAL_POLL_RESP = 3;
	localparam int CFG_AUX_MODE         = 4;
	localparam int CFG_BUS_CONTROL      = 5;
	localparam int CFG_MISC             = 6;
	localparam int CFG_HS_INT_ENABLE    = 7;
	localparam int CFG_END_OF_STRING    = 8;
	localparam int CFG_SETTLE_DELAY     = 9;
	localparam int CFG_PARALLEL_POLL    = 10;

	// bank members cleared by the transfer-manager reset; the rest by the bus-side reset
	localparam logic [CFG_COUNT-1:0] XFER_GROUP = 11'h007;

	// command codes
	localparam logic [7:0] CMD_XFER_RESET = 8'h22;
	localparam logic [7:0] CMD_FULL_RESET = 8'h40;
	localparam logic [7:0] CMD_GO         = 8'h04;
	localparam logic [7:0] AUX_BUS_RESET  = 8'h02;
	localparam logic [7:0] AUX_PON_PULSE  = 8'h00;

	// field positions
	localparam int POLL_MODE_ONE_BIT = 7;
	localparam int CTL_LEGACY_MODE   = 0;
	localparam int CTL_COUNT_16BIT   = 1;
	localparam int CTL_IST           = 2;
	localparam int ST_SYNC           = 0;
	localparam int ST_STOPPED        = 1;
	localparam int ST_DONE           = 2;
	localparam int ST_PON            = 3;
	localparam int ST_NATIVE         = 4;
	localparam int ST_COUNT_16BIT    = 5;
	localparam int ST_IST            = 6;
	localparam int ST_PCI_MODE       = 7;

	// reset values
	localparam logic [7:0] CFG_RESET_VAL = 8'h00;
	localparam logic [7:0] PPC_RESET_VAL = 8'h80;

	typedef logic [CFG_COUNT-1:0][7:0] cfg_bank_t;

	typedef struct packed {
		logic native_mode;
		logic count_16bit;
		logic individual_status;
		logic bus_synchronized;
		logic transfer_done;
		logic transfer_stopped;
		logic pon;
	} reset_state_t;

	typedef enum logic [1:0] {
		PON_HELD,
		PON_PULSE,
		PON_OFF
	} pon_state_t;

endpackage : reset_mgr_pkg

/* verif/bus_interface_reset_manager_checker.sv */
// port checker for the bus-interface reset manager
`timescale 1ns/1ps
module bus_interface_reset_manager_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// reset pins and actions
	input wire logic pci_host_mode,
	input wire logic pci_rst_n,
	input wire logic gen_rst_n,
	input wire logic pci_if_reset,
	input wire logic xfer_mgr_reset,
	input wire logic bus_side_reset,
	input wire logic fifo_flush,
	// state
	input wire reset_mgr_pkg::reset_state_t state,
	input wire reset_mgr_pkg::cfg_bank_t    cfg_regs
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic       pin_n;
	logic       cw;
	logic       aw;
	logic [7:0] cmd;
	// pin that the strap selects, as the device sees it
	assign pin_n = pci_host_mode ? pci_rst_n : gen_rst_n;
	assign cmd   = pwdata[7:0];
	assign cw    = psel && penable && pready && pwrite && paddr == 12'h040 && pin_n;
	assign aw    = psel && penable && pready && pwrite && paddr == 12'h028 && pin_n;
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("setup not answered next cycle");
	property p_xfer;
		cw && cmd == 8'h22 |=> xfer_mgr_reset && fifo_flush && !bus_side_reset;
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer reset pulses wrong");
	property p_xfer_state;
		cw && cmd == 8'h22 |-> ##2 state.native_mode && state.count_16bit
			&& state.bus_synchronized && state.transfer_done && state.transfer_stopped
			&& cfg_regs[0] == 8'h00 && cfg_regs[1] == 8'h00 && cfg_regs[2] == 8'h00;
	endproperty
	a_xfer_state: assert property (p_xfer_state) else $error("transfer reset state wrong");
	property p_full;
		cw && cmd == 8'h40 |=> xfer_mgr_reset && bus_side_reset
			&& pci_if_reset == pci_host_mode;
	endproperty
	a_full: assert property (p_full) else $error("full reset command incomplete");
	property p_hold;
		aw && cmd == 8'h02 |=> bus_side_reset ##1 state.pon && !state.individual_status
			&& cfg_regs[10] == 8'h80 && cfg_regs[3] == 8'h00 && cfg_regs[9] == 8'h00;
	endproperty
	a_hold: assert property (p_hold) else $error("bus-side reset incomplete");
	property p_pulse;
		aw && cmd == 8'h00 |-> ##2 state.pon ##1 !state.pon;
	endproperty
	a_pulse: assert property (p_pulse) else $error("power-on pulse not one cycle");
	property p_stays;
		state.pon && !$past(aw && cmd == 8'h00, 2) |=> state.pon;
	endproperty
	a_stays: assert property (p_stays) else $error("power-on dropped by itself");
	property p_go;
		cw && cmd == 8'h04 |-> ##2 !state.bus_synchronized;
	endproperty
	a_go: assert property (p_go) else $error("go left sync flag set");
	property p_pin;
		!pin_n |-> ##[1:2] xfer_mgr_reset && bus_side_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("reset pin ignored");
	property p_pci;
		pci_host_mode && !pci_rst_n |-> ##[1:2] pci_if_reset;
	endproperty
	a_pci: assert property (p_pci) else $error("pci interface not reset");
	property p_other;
		(cw && !(cmd inside {8'h22, 8'h40, 8'h04})) || (aw && !(cmd inside {8'h00, 8'h02}))
			|=> !xfer_mgr_reset && !bus_side_reset;
	endproperty
	a_other: assert property (p_other) else $error("stray code caused reset");
	c_xfer: cover property (cw && cmd == 8'h22);
	c_pulse: cover property (aw && cmd == 8'h00);
	c_pin: cover property (!pin_n);
endmodule : bus_interface_reset_manager_checker

bind bus_interface_reset_manager bus_interface_reset_manager_checker chk (.clock, .rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pci_host_mode, .pci_rst_n, .gen_rst_n,
	.pci_if_reset, .xfer_mgr_reset, .bus_side_reset, .fifo_flush, .state, .cfg_regs);

/* verif/bus_interface_reset_manager_test.sv */
// self-checking bench for the bus-interface reset manager
`timescale 1ns/1ps
module bus_interface_reset_manager_test;
	logic                        clock, rst, psel, penable, pwrite, pready, pslverr;
	logic                        pci_host_mode, pci_rst_n, gen_rst_n;
	logic                        pci_if_reset, xfer_mgr_reset, bus_side_reset, fifo_flush;
	logic [11:0]                 paddr;
	logic [31:0]                 pwdata, prdata;
	logic [15:0]                 junk [4];
	reset_mgr_pkg::reset_state_t state, es;
	reset_mgr_pkg::cfg_bank_t    cfg_regs, ec;
	int                          miscompares, n_compared;

	bus_interface_reset_manager dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .pci_host_mode, .pci_rst_n, .gen_rst_n, .pci_if_reset,
		.xfer_mgr_reset, .bus_side_reset, .fifo_flush, .state, .cfg_regs);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [31:0] exp, input logic err);
		int n;
		paddr <= {2'b00, idx, 2'b00};
		pwrite <= w;
		pwdata <= {24'h0, d};
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			tally_and_finish();
		end
		chk("prdata", prdata, exp);
		chk("pslverr", {31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	function automatic logic [31:0] stat();
		return {24'h0, pci_host_mode, es.individual_status, es.count_16bit, es.native_mode,
			es.pon, es.transfer_done, es.transfer_stopped, es.bus_synchronized};
	endfunction : stat

	task automatic xreset();
		ec[2:0] = '0;
		{es.native_mode, es.count_16bit} = 2'b11;
		{es.bus_synchronized, es.transfer_done, es.transfer_stopped} = 3'b111;
	endtask : xreset

	task automatic breset();
		ec[9:3] = '0;
		ec[10] = 8'h80;
		es.individual_status = 1'b0;
		es.pon = 1'b1;
	endtask : breset

	// loads the whole bank, legacy mode, 8-bit count, ist set, then go
	task automatic fill(input logic [7:0] seed);
		for (int i = 0; i < 11; i++) begin
			ec[i] = seed + 8'(i);
			apb(1'b1, reset_mgr_pkg::IDX_CFG_BASE + 8'(i), ec[i], 32'h0, 1'b0);
		end
		apb(1'b1, reset_mgr_pkg::IDX_CONTROL, 8'h05, 32'h0, 1'b0);
		apb(1'b1, reset_mgr_pkg::IDX_XFER_CMD, 8'h04, 32'h0, 1'b0);
		{es.native_mode, es.count_16bit, es.individual_status} = 3'b001;
		{es.bus_synchronized, es.transfer_done, es.transfer_stopped} = 3'b000;
	endtask : fill

	// state trails a write by two cycles, so look after both have landed
	task automatic check_all(input string tn);
		@(negedge clock);
		@(negedge clock);
		chk("state", {25'h0, state}, {25'h0, es});
		for (int i = 0; i < 11; i++)
			chk("cfg_regs", {24'h0, cfg_regs[i]}, {24'h0, ec[i]});
		$display("test %s done", tn);
		@(posedge clock);
	endtask : check_all

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pci_host_mode, pci_rst_n, gen_rst_n} = 3'b111;
		{miscompares, n_compared} = '0;
		junk = '{16'h1033, 16'h10ff, 16'h0a5b, 16'h0a01};
		es = '0;
		ec = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		xreset();
		breset();
		check_all("reset");
		apb(1'b0, reset_mgr_pkg::IDX_STATUS, 8'h00, stat(), 1'b0);
		apb(1'b0, reset_mgr_pkg::IDX_AUX_CMD, 8'h00, 32'h0, 1'b0);
		apb(1'b0, 8'h7f, 8'h00, 32'h0, 1'b1);
		fill(8'h30);
		check_all("setup");
		apb(1'b1, reset_mgr_pkg::IDX_XFER_CMD, 8'h22, 32'h0, 1'b0);
		xreset();
		check_all("transfer reset");
		apb(1'b0, reset_mgr_pkg::IDX_STATUS, 8'h00, stat(), 1'b0);
		foreach (junk[k])
			apb(1'b1, junk[k][15:8], junk[k][7:0], 32'h0, 1'b0);
		check_all("other codes");
		apb(1'b1, reset_mgr_pkg::IDX_AUX_CMD, 8'h00, 32'h0, 1'b0);
		es.pon = 1'b0;
		check_all("pon pulse");
		fill(8'h50);
		apb(1'b1, reset_mgr_pkg::IDX_AUX_CMD, 8'h02, 32'h0, 1'b0);
		breset();
		check_all("bus reset");
		repeat (40) @(posedge clock);
		check_all("pon held");
		fill(8'h70);
		apb(1'b1, reset_mgr_pkg::IDX_XFER_CMD, 8'h40, 32'h0, 1'b0);
		xreset();
		breset();
		check_all("full reset");
		for (int m = 0; m < 2; m++) begin
			pci_host_mode <= m[0];
			fill(8'h90);
			if (m == 0)
				gen_rst_n <= 1'b0;
			else
				pci_rst_n <= 1'b0;
			repeat (3) @(posedge clock);
			{gen_rst_n, pci_rst_n} <= 2'b11;
			@(posedge clock);
			xreset();
			breset();
			check_all("reset pin");
			apb(1'b0, reset_mgr_pkg::IDX_STATUS, 8'h00, stat(), 1'b0);
		end
		tally_and_finish();
	end
endmodule : bus_interface_reset_manager_test
